// *** verilog/cpu_decode_core.sv ***
`timescale 1ns/1ps
`include "cpu_decode_map.svh"

// What this block does
// [RQ1] Register-to-register add takes the first operand byte as source and the second as destination.
// [RQ2] An 8-bit register operand reaches 240 of the 256 registers in its page, or a working register when escaped.
// [RQ3] Subtract with borrow (opcodes 32 to 37) writes dst minus src minus carry and sets the D flag.
// [RQ4] Extended subtract with borrow (38, 39) uses 12-bit addresses, with an immediate source on 39.
// [RQ5] Extended pop (D8) loads dst from the byte at the stack pointer, then adds one to the pointer.
// [RQ6] Extended push (C8) subtracts one from the stack pointer, then stores src at that location.
// [RQ7] Return (AF) loads the program counter from two stack bytes and adds two to the pointer.
// [RQ8] Rotate right (E0 direct, E1 indirect) moves bit 0 into bit 7 and into carry.
// [RQ9] Rotate right through carry (C0, C1) moves old carry into bit 7 and bit 0 into carry.
// [RQ10] Result flags come from the outcome, unaffected flags hold and forced flags take 0 or 1.
// [RQ11] Only listed flags change, and only stack and program control touch the pointer and counter.
module cpu_decode_core
	import cpu_decode_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                sys_rst,
	output logic      [15:0]         pm_addr,
	input  wire logic [7:0]          pm_rdata,
	output logic      [11:0]         mem_addr,
	output logic                     mem_re,
	output logic                     mem_we,
	output logic      [7:0]          mem_wdata,
	input  wire logic [7:0]          mem_rdata,
	input  wire logic [7:0]          reg_pointer,
	output logic      [`FLAGS_W-1:0] flags,
	output logic      [11:0]         stack_pointer,
	output logic                     instr_done,
	output logic                     illegal_opcode
);

	import cpu_decode_pkg::*;

	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	state_t              state_reg,    state_next;
	logic [15:0]         pc_reg,       pc_next;
	logic [11:0]         sp_reg,       sp_next;
	logic [`FLAGS_W-1:0] flags_reg,    flags_next;
	logic [7:0]          op_reg,       op_next;
	logic [7:0]          b1_reg,       b1_next;
	logic [7:0]          b2_reg,       b2_next;
	logic [7:0]          b3_reg,       b3_next;
	logic [2:0]          len_reg,      len_next;
	logic [2:0]          cnt_reg,      cnt_next;
	logic [11:0]         src_addr_reg, src_addr_next;
	logic [11:0]         dst_addr_reg, dst_addr_next;
	logic [7:0]          src_val_reg,  src_val_next;
	logic [7:0]          dst_val_reg,  dst_val_next;
	logic [7:0]          hi_reg,       hi_next;
	logic                ind_src_reg,  ind_src_next;
	alu_op_t             alu_op_reg,   alu_op_next;
	logic [11:0]         maddr_reg,    maddr_next;
	logic                re_reg,       re_next;
	logic                we_reg,       we_next;
	logic [7:0]          wdata_reg,    wdata_next;
	logic                done_reg,     done_next;
	logic                illegal_reg,  illegal_next;

	// ----------------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------------
	logic [11:0]         src_field;
	logic [11:0]         dst_field;
	logic                src_ext;
	logic                dst_ext;
	logic [7:0]          dec_imm;
	logic                dec_ind_src;
	logic                dec_ind_dst;
	alu_op_t             dec_alu;
	state_t              dec_first;
	logic [11:0]         src_res;
	logic [11:0]         dst_res;
	logic [11:0]         ptr_res;
	logic [7:0]          alu_result;
	logic [`FLAGS_W-1:0] alu_flags;

	function automatic logic [2:0] instr_len(input logic [7:0] opc);
		case (opc)
			`OPC_RETURN:            instr_len = `LEN_ONE;
			`OPC_SUB_BORROW_WW,
			`OPC_SUB_BORROW_WI,
			`OPC_ROT_DIRECT,
			`OPC_ROT_INDIRECT,
			`OPC_ROT_CARRY_DIRECT,
			`OPC_ROT_CARRY_INDIRECT: instr_len = `LEN_TWO;
			`OPC_ADD_DD,
			`OPC_SUB_BORROW_DD,
			`OPC_SUB_BORROW_DI,
			`OPC_SUB_BORROW_DK,
			`OPC_SUB_BORROW_IK,
			`OPC_POP_EXT,
			`OPC_PUSH_EXT:          instr_len = `LEN_THREE;
			`OPC_SUB_BORROW_EXT_EE,
			`OPC_SUB_BORROW_EXT_EK: instr_len = `LEN_FOUR;
			default:                instr_len = `LEN_NONE;
		endcase
	endfunction

	always_comb begin
		src_field   = {`PAGE_ZERO, b1_reg};
		dst_field   = {`PAGE_ZERO, b2_reg};
		src_ext     = 1'b0;
		dst_ext     = 1'b0;
		dec_imm     = `BYTE_ZERO;
		dec_ind_src = 1'b0;
		dec_ind_dst = 1'b0;
		dec_alu     = ALU_SUB_BORROW;
		dec_first   = S_SRC;
		case (op_reg)
			`OPC_ADD_DD: begin
				dec_alu = ALU_ADD; // RQ1
			end
			`OPC_SUB_BORROW_WW, `OPC_SUB_BORROW_WI: begin
				src_field   = {`PAGE_ZERO, `ESC_NIBBLE, b1_reg[3:0]}; // RQ2 RQ3
				dst_field   = {`PAGE_ZERO, `ESC_NIBBLE, b1_reg[7:4]};
				dec_ind_src = (op_reg == `OPC_SUB_BORROW_WI);
				dec_first   = dec_ind_src ? S_IND : S_SRC;
			end
			`OPC_SUB_BORROW_DD, `OPC_SUB_BORROW_DI: begin
				dec_ind_src = (op_reg == `OPC_SUB_BORROW_DI); // RQ3
				dec_first   = dec_ind_src ? S_IND : S_SRC;
			end
			`OPC_SUB_BORROW_DK, `OPC_SUB_BORROW_IK: begin
				dst_field   = {`PAGE_ZERO, b1_reg}; // RQ3
				dec_imm     = b2_reg;
				dec_ind_dst = (op_reg == `OPC_SUB_BORROW_IK);
				dec_first   = dec_ind_dst ? S_IND : S_DST;
			end
			`OPC_SUB_BORROW_EXT_EE: begin
				src_field = {b1_reg, b2_reg[7:4]}; // RQ4
				dst_field = {b2_reg[3:0], b3_reg};
				src_ext   = 1'b1;
				dst_ext   = 1'b1;
			end
			`OPC_SUB_BORROW_EXT_EK: begin
				dec_imm   = b1_reg; // RQ4
				dst_field = {b2_reg[3:0], b3_reg};
				dst_ext   = 1'b1;
				dec_first = S_DST;
			end
			`OPC_POP_EXT: begin
				dst_field = {b1_reg, b2_reg[7:4]}; // RQ5
				dst_ext   = 1'b1;
				dec_first = S_STK;
			end
			`OPC_PUSH_EXT: begin
				src_field = {b1_reg, b2_reg[7:4]}; // RQ6
				src_ext   = 1'b1;
			end
			`OPC_RETURN: begin
				dec_first = S_STK; // RQ7
			end
			`OPC_ROT_DIRECT, `OPC_ROT_INDIRECT,
			`OPC_ROT_CARRY_DIRECT, `OPC_ROT_CARRY_INDIRECT: begin
				dst_field   = {`PAGE_ZERO, b1_reg};
				dec_alu     = op_reg[5] ? ALU_ROT : ALU_ROT_CARRY; // RQ8 RQ9
				dec_ind_dst = op_reg[0];
				dec_first   = dec_ind_dst ? S_IND : S_DST;
			end
			default: begin
				dec_first = S_FETCH;
			end
		endcase
	end

	reg_addr_resolve u_src_res (
		.ext_mode    (src_ext),
		.addr_in     (src_field),
		.reg_pointer (reg_pointer),
		.addr_out    (src_res)
	);

	reg_addr_resolve u_dst_res (
		.ext_mode    (dst_ext),
		.addr_in     (dst_field),
		.reg_pointer (reg_pointer),
		.addr_out    (dst_res)
	);

	reg_addr_resolve u_ptr_res (
		.ext_mode    (1'b0),
		.addr_in     ({`PAGE_ZERO, mem_rdata}),
		.reg_pointer (reg_pointer),
		.addr_out    (ptr_res)
	);

	cpu_alu u_alu (
		.dst_val   (dst_val_reg),
		.src_val   (src_val_reg),
		.flags_in  (flags_reg),
		.op        (alu_op_reg),
		.result    (alu_result),
		.flags_out (alu_flags)
	);

	// ----------------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------------
	always_comb begin
		state_next    = state_reg;
		pc_next       = pc_reg;
		sp_next       = sp_reg;
		flags_next    = flags_reg;
		op_next       = op_reg;
		b1_next       = b1_reg;
		b2_next       = b2_reg;
		b3_next       = b3_reg;
		len_next      = len_reg;
		cnt_next      = cnt_reg;
		src_addr_next = src_addr_reg;
		dst_addr_next = dst_addr_reg;
		src_val_next  = src_val_reg;
		dst_val_next  = dst_val_reg;
		hi_next       = hi_reg;
		ind_src_next  = ind_src_reg;
		alu_op_next   = alu_op_reg;
		wdata_next    = wdata_reg;
		we_next       = 1'b0;
		done_next     = 1'b0;
		illegal_next  = 1'b0;
		case (state_reg)
			S_FETCH: begin
				pc_next  = pc_reg + `PC_STEP;
				cnt_next = cnt_reg + `CNT_ONE;
				if (cnt_reg == `CNT_ZERO) begin
					op_next  = pm_rdata;
					len_next = instr_len(pm_rdata);
					if (len_next == `LEN_NONE) begin
						illegal_next = 1'b1;
						cnt_next     = `CNT_ZERO;
					end else if (len_next == `LEN_ONE) begin
						state_next = S_DECODE;
						cnt_next   = `CNT_ZERO;
					end
				end else begin
					if (cnt_reg == `CNT_ONE) begin
						b1_next = pm_rdata; // RQ1
					end
					if (cnt_reg == `CNT_TWO) begin
						b2_next = pm_rdata; // RQ1
					end
					if (cnt_reg == `CNT_THREE) begin
						b3_next = pm_rdata;
					end
					if (cnt_next == len_reg) begin
						state_next = S_DECODE;
						cnt_next   = `CNT_ZERO;
					end
				end
			end
			S_DECODE: begin
				src_addr_next = src_res;
				dst_addr_next = dst_res;
				src_val_next  = dec_imm;
				ind_src_next  = dec_ind_src;
				alu_op_next   = dec_alu;
				state_next    = dec_first;
			end
			S_IND: begin
				if (ind_src_reg) begin
					src_addr_next = ptr_res;
					state_next    = S_SRC;
				end else begin
					dst_addr_next = ptr_res;
					state_next    = S_DST;
				end
			end
			S_SRC: begin
				src_val_next = mem_rdata;
				state_next   = (op_reg == `OPC_PUSH_EXT) ? S_EXEC : S_DST;
			end
			S_DST: begin
				dst_val_next = mem_rdata;
				state_next   = S_EXEC;
			end
			S_STK: begin
				if (op_reg == `OPC_RETURN) begin
					hi_next    = mem_rdata; // RQ7
					state_next = S_STK2;
				end else begin
					src_val_next = mem_rdata; // RQ5
					state_next   = S_EXEC;
				end
			end
			S_STK2: begin
				src_val_next = mem_rdata; // RQ7
				state_next   = S_EXEC;
			end
			S_EXEC: begin
				we_next    = 1'b1;
				state_next = S_WB;
				case (op_reg)
					`OPC_RETURN: begin
						pc_next    = {hi_reg, src_val_reg}; // RQ7
						sp_next    = sp_reg + `STACK_STEP2; // RQ7
						we_next    = 1'b0;
						done_next  = 1'b1;
						state_next = S_FETCH;
					end
					`OPC_POP_EXT: begin
						wdata_next = src_val_reg; // RQ5
						sp_next    = sp_reg + `STACK_STEP; // RQ5
					end
					`OPC_PUSH_EXT: begin
						wdata_next = src_val_reg; // RQ6
						sp_next    = sp_reg - `STACK_STEP; // RQ6
					end
					default: begin
						wdata_next = alu_result;
						flags_next = alu_flags; // RQ10 RQ11
					end
				endcase
			end
			S_WB: begin
				done_next  = 1'b1;
				state_next = S_FETCH;
			end
			default: begin
				state_next = S_FETCH;
			end
		endcase
		re_next    = 1'b1;
		maddr_next = maddr_reg;
		case (state_next)
			S_IND:   maddr_next = ind_src_next ? src_addr_next : dst_addr_next;
			S_SRC:   maddr_next = src_addr_next;
			S_DST:   maddr_next = dst_addr_next;
			S_STK:   maddr_next = sp_next;
			S_STK2:  maddr_next = sp_next + `STACK_STEP;
			S_WB: begin
				re_next    = 1'b0;
				maddr_next = (op_reg == `OPC_PUSH_EXT) ? sp_next : dst_addr_next; // RQ6
			end
			default: re_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg    <= S_FETCH;
			pc_reg       <= `PC_RESET;
			sp_reg       <= `STACK_RESET;
			flags_reg    <= `FLAGS_RESET;
			op_reg       <= `BYTE_ZERO;
			b1_reg       <= `BYTE_ZERO;
			b2_reg       <= `BYTE_ZERO;
			b3_reg       <= `BYTE_ZERO;
			len_reg      <= `LEN_NONE;
			cnt_reg      <= `CNT_ZERO;
			src_addr_reg <= `STACK_RESET;
			dst_addr_reg <= `STACK_RESET;
			src_val_reg  <= `BYTE_ZERO;
			dst_val_reg  <= `BYTE_ZERO;
			hi_reg       <= `BYTE_ZERO;
			ind_src_reg  <= 1'b0;
			alu_op_reg   <= ALU_ADD;
			maddr_reg    <= `STACK_RESET;
			re_reg       <= 1'b0;
			we_reg       <= 1'b0;
			wdata_reg    <= `BYTE_ZERO;
			done_reg     <= 1'b0;
			illegal_reg  <= 1'b0;
		end else begin
			state_reg    <= state_next;
			pc_reg       <= pc_next;
			sp_reg       <= sp_next;
			flags_reg    <= flags_next;
			op_reg       <= op_next;
			b1_reg       <= b1_next;
			b2_reg       <= b2_next;
			b3_reg       <= b3_next;
			len_reg      <= len_next;
			cnt_reg      <= cnt_next;
			src_addr_reg <= src_addr_next;
			dst_addr_reg <= dst_addr_next;
			src_val_reg  <= src_val_next;
			dst_val_reg  <= dst_val_next;
			hi_reg       <= hi_next;
			ind_src_reg  <= ind_src_next;
			alu_op_reg   <= alu_op_next;
			maddr_reg    <= maddr_next;
			re_reg       <= re_next;
			we_reg       <= we_next;
			wdata_reg    <= wdata_next;
			done_reg     <= done_next;
			illegal_reg  <= illegal_next;
		end
	end

	// ----------------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------------
	assign pm_addr        = pc_reg;
	assign mem_addr       = maddr_reg;
	assign mem_re         = re_reg;
	assign mem_we         = we_reg;
	assign mem_wdata      = wdata_reg;
	assign flags          = flags_reg;
	assign stack_pointer  = sp_reg;
	assign instr_done     = done_reg;
	assign illegal_opcode = illegal_reg;

endmodule

// *** verilog/cpu_decode_map.svh ***
`ifndef CPU_DECODE_MAP_SVH
`define CPU_DECODE_MAP_SVH

// --------------------------------------------------------------------------
// Opcodes
// --------------------------------------------------------------------------
`define OPC_ADD_DD            8'h04
`define OPC_SUB_BORROW_WW     8'h32
`define OPC_SUB_BORROW_WI     8'h33
`define OPC_SUB_BORROW_DD     8'h34
`define OPC_SUB_BORROW_DI     8'h35
`define OPC_SUB_BORROW_DK     8'h36
`define OPC_SUB_BORROW_IK     8'h37
`define OPC_SUB_BORROW_EXT_EE 8'h38
`define OPC_SUB_BORROW_EXT_EK 8'h39
`define OPC_POP_EXT           8'hD8
`define OPC_PUSH_EXT          8'hC8
`define OPC_RETURN            8'hAF
`define OPC_ROT_DIRECT        8'hE0
`define OPC_ROT_INDIRECT      8'hE1
`define OPC_ROT_CARRY_DIRECT  8'hC0
`define OPC_ROT_CARRY_INDIRECT 8'hC1

// --------------------------------------------------------------------------
// Instruction lengths in bytes
// --------------------------------------------------------------------------
`define LEN_NONE  3'h0
`define LEN_ONE   3'h1
`define LEN_TWO   3'h2
`define LEN_THREE 3'h3
`define LEN_FOUR  3'h4
`define CNT_ZERO  3'h0
`define CNT_ONE   3'h1
`define CNT_TWO   3'h2
`define CNT_THREE 3'h3

// --------------------------------------------------------------------------
// Flag bit positions
// --------------------------------------------------------------------------
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_S 2
`define FLAG_V 3
`define FLAG_D 4
`define FLAG_H 5
`define FLAGS_W 6

// --------------------------------------------------------------------------
// Reset values, steps and address escapes
// --------------------------------------------------------------------------
`define FLAGS_RESET  6'h00
`define STACK_RESET  12'h000
`define PC_RESET     16'h0000
`define PC_STEP      16'h0001
`define STACK_STEP   12'h001
`define STACK_STEP2  12'h002
`define ESC_NIBBLE   4'hE
`define EXT_ESC_BYTE 8'hEE
`define PAGE_ZERO    4'h0
`define BYTE_ZERO    8'h00

`endif

// *** verilog/cpu_decode_pkg.sv ***
package cpu_decode_pkg;

	typedef enum logic [3:0] {
		S_FETCH  = 4'h0,
		S_DECODE = 4'h1,
		S_IND    = 4'h2,
		S_SRC    = 4'h3,
		S_DST    = 4'h4,
		S_STK    = 4'h5,
		S_STK2   = 4'h6,
		S_EXEC   = 4'h7,
		S_WB     = 4'h8
	} state_t;

	typedef enum logic [1:0] {
		ALU_ADD        = 2'h0,
		ALU_SUB_BORROW = 2'h1,
		ALU_ROT        = 2'h2,
		ALU_ROT_CARRY  = 2'h3
	} alu_op_t;

endpackage

// *** verilog/reg_addr_resolve.sv ***
`timescale 1ns/1ps
`include "cpu_decode_map.svh"

module reg_addr_resolve (
	input  wire logic        ext_mode,
	input  wire logic [11:0] addr_in,
	input  wire logic [7:0]  reg_pointer,
	output logic      [11:0] addr_out
);

	logic [11:0] working;

	always_comb begin
		working = {reg_pointer[3:0], reg_pointer[7:4], addr_in[3:0]};
		if (ext_mode) begin
			addr_out = (addr_in[11:4] == `EXT_ESC_BYTE) ? working : addr_in; // RQ2
		end else begin
			addr_out = (addr_in[7:4] == `ESC_NIBBLE) ? working : {reg_pointer[3:0], addr_in[7:0]}; // RQ2
		end
	end

endmodule

// *** verilog/cpu_alu.sv ***
`timescale 1ns/1ps
`include "cpu_decode_map.svh"

module cpu_alu
	import cpu_decode_pkg::*;
(
	input  wire logic [7:0]          dst_val,
	input  wire logic [7:0]          src_val,
	input  wire logic [`FLAGS_W-1:0] flags_in,
	input  wire cpu_decode_pkg::alu_op_t op,
	output logic      [7:0]          result,
	output logic      [`FLAGS_W-1:0] flags_out
);

	logic [8:0] wide;
	logic [4:0] half;
	logic       cin;

	always_comb begin
		cin       = flags_in[`FLAG_C];
		flags_out = flags_in;
		wide      = 9'h000;
		half      = 5'h00;
		case (op)
			ALU_ADD: begin
				wide = {1'b0, dst_val} + {1'b0, src_val};
				half = {1'b0, dst_val[3:0]} + {1'b0, src_val[3:0]};
				flags_out[`FLAG_C] = wide[8];
				flags_out[`FLAG_V] = (dst_val[7] == src_val[7]) && (wide[7] != dst_val[7]);
				flags_out[`FLAG_D] = 1'b0;
				flags_out[`FLAG_H] = half[4];
			end
			ALU_SUB_BORROW: begin
				wide = {1'b0, dst_val} - {1'b0, src_val} - {8'h00, cin}; // RQ3 RQ4
				half = {1'b0, dst_val[3:0]} - {1'b0, src_val[3:0]} - {4'h0, cin};
				flags_out[`FLAG_C] = wide[8]; // RQ10
				flags_out[`FLAG_V] = (dst_val[7] != src_val[7]) && (wide[7] != dst_val[7]);
				flags_out[`FLAG_D] = 1'b1; // RQ3
				flags_out[`FLAG_H] = half[4];
			end
			ALU_ROT: begin
				wide = {dst_val[0], dst_val[0], dst_val[7:1]}; // RQ8
				flags_out[`FLAG_C] = dst_val[0]; // RQ8
				flags_out[`FLAG_V] = wide[7] ^ dst_val[7];
			end
			ALU_ROT_CARRY: begin
				wide = {dst_val[0], cin, dst_val[7:1]}; // RQ9
				flags_out[`FLAG_C] = dst_val[0]; // RQ9
				flags_out[`FLAG_V] = wide[7] ^ dst_val[7];
			end
			default: begin
				wide = {1'b0, dst_val};
			end
		endcase
		result             = wide[7:0];
		flags_out[`FLAG_Z] = (wide[7:0] == `BYTE_ZERO); // RQ10
		flags_out[`FLAG_S] = wide[7]; // RQ10
	end

endmodule

// *** verification/cpu_mem_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Program memory and register file model
// ----------------------------------------
module cpu_mem_model (
	input  wire logic        clk,
	input  wire logic [15:0] pm_addr,
	output logic      [7:0]  pm_rdata,
	input  wire logic [11:0] mem_addr,
	input  wire logic        mem_re,
	input  wire logic        mem_we,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata
);
	logic [7:0] pm   [256];
	logic [7:0] regs [4096];

	initial begin
		foreach (pm[i]) pm[i] = 8'hFF;
		foreach (regs[i]) regs[i] = 8'h00;
	end

	assign pm_rdata = pm[pm_addr[7:0]];
	// Outside a read the lines show the inverse, so a stale byte never passes.
	assign mem_rdata = mem_re ? regs[mem_addr] : ~regs[mem_addr];

	always @(posedge clk) begin
		if (mem_we) begin
			regs[mem_addr] <= mem_wdata;
		end
	end
endmodule

// *** verification/cpu_decode_core_monitor.sv ***
`timescale 1ns/1ps
`include "cpu_decode_map.svh"

// ----------------------------------------
// Port checker
// ----------------------------------------
module cpu_decode_core_monitor (
	input wire logic                clk,
	input wire logic                sys_rst,
	input wire logic [15:0]         pm_addr,
	input wire logic [11:0]         mem_addr,
	input wire logic                mem_re,
	input wire logic                mem_we,
	input wire logic [`FLAGS_W-1:0] flags,
	input wire logic [11:0]         stack_pointer,
	input wire logic                instr_done,
	input wire logic                illegal_opcode
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_sp_dec;
		$changed(stack_pointer) && (stack_pointer == $past(stack_pointer) - 12'h001);
	endsequence
	sequence s_sp_inc1;
		$changed(stack_pointer) && (stack_pointer == $past(stack_pointer) + 12'h001);
	endsequence
	sequence s_sp_inc2;
		$changed(stack_pointer) && (stack_pointer == $past(stack_pointer) + 12'h002);
	endsequence
	sequence s_stack_write;
		mem_we && (mem_addr == stack_pointer);
	endsequence

	property p_reset;
		disable iff (1'b0) sys_rst |=> (pm_addr == 16'h0000) && (stack_pointer == 12'h000)
			&& (flags == 6'h00) && !mem_we && !instr_done
			&& !mem_re && (mem_addr == 12'h000) && !illegal_opcode;
	endproperty
	property p_we_pulse;
		mem_we |=> !mem_we;
	endproperty
	property p_done_after_write;
		mem_we |=> instr_done;
	endproperty
	property p_flags_cause;
		$changed(flags) |-> mem_we || $past(mem_we);
	endproperty
	property p_sp_step;
		$changed(stack_pointer) |-> (stack_pointer == $past(stack_pointer) + 12'h001)
			|| (stack_pointer == $past(stack_pointer) - 12'h001)
			|| (stack_pointer == $past(stack_pointer) + 12'h002);
	endproperty
	property p_sp_keeps_flags;
		$changed(stack_pointer) |-> $stable(flags);
	endproperty
	property p_push_write;
		s_sp_dec |-> ##[0:4] s_stack_write;
	endproperty
	property p_pop_write;
		s_sp_inc1 |-> ##[0:3] mem_we;
	endproperty
	property p_return_done;
		s_sp_inc2 |-> !mem_we ##[0:2] instr_done;
	endproperty
	property p_illegal_quiet;
		illegal_opcode |-> !mem_we && !instr_done;
	endproperty

	a_reset: assert property (p_reset) else $error("reset values wrong");
	a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
	a_done_after_write: assert property (p_done_after_write) else $error("no done");
	a_flags_cause: assert property (p_flags_cause) else $error("flags moved alone");
	a_sp_step: assert property (p_sp_step) else $error("stack step wrong");
	a_sp_keeps_flags: assert property (p_sp_keeps_flags) else $error("flags hit");
	a_push_write: assert property (p_push_write) else $error("push store missing");
	a_pop_write: assert property (p_pop_write) else $error("pop load missing");
	a_return_done: assert property (p_return_done) else $error("return wrong");
	a_illegal_quiet: assert property (p_illegal_quiet) else $error("illegal acted");
endmodule

bind cpu_decode_core cpu_decode_core_monitor i_cpu_decode_core_monitor (
	.clk(clk), .sys_rst(sys_rst), .pm_addr(pm_addr), .mem_addr(mem_addr),
	.mem_re(mem_re), .mem_we(mem_we), .flags(flags), .stack_pointer(stack_pointer),
	.instr_done(instr_done), .illegal_opcode(illegal_opcode)
);

// *** verification/cpu_decode_core_tb.sv ***
`timescale 1ns/1ps
`include "cpu_decode_map.svh"

module cpu_decode_core_tb;
	import cpu_decode_pkg::*;

	logic                clk = 1'b0;
	logic                sys_rst = 1'b1;
	logic [15:0]         pm_addr;
	logic [7:0]          pm_rdata;
	logic [11:0]         mem_addr;
	logic                mem_re;
	logic                mem_we;
	logic [7:0]          mem_wdata;
	logic [7:0]          mem_rdata;
	logic [7:0]          reg_pointer = 8'h00;
	logic [`FLAGS_W-1:0] flags;
	logic [11:0]         stack_pointer;
	logic                instr_done;
	logic                illegal_opcode;
	int                  mismatches = 0;
	int                  n_checks = 0;
	int                  cycles = 0;

	always #12.5 clk = ~clk;

	cpu_decode_core i_cpu_decode_core (.clk(clk), .sys_rst(sys_rst), .pm_addr(pm_addr),
		.pm_rdata(pm_rdata), .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .reg_pointer(reg_pointer),
		.flags(flags), .stack_pointer(stack_pointer), .instr_done(instr_done),
		.illegal_opcode(illegal_opcode));
	cpu_mem_model i_cpu_mem_model (.clk(clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
		.mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [15:0] rf(input logic [11:0] a);
		return 16'(i_cpu_mem_model.regs[a]);
	endfunction

	task automatic put_code(input logic [7:0] a, input logic [7:0] q[$]);
		foreach (q[i]) i_cpu_mem_model.pm[a + 8'(i)] = q[i];
	endtask

	task automatic do_reset(input logic [7:0] rp);
		@(posedge clk);
		sys_rst <= 1'b1;
		reg_pointer <= rp;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		check("pm_addr", pm_addr, 16'h0000);
		check("sp", 16'(stack_pointer), 16'h0000);
		check("flags", 16'(flags), 16'h0000);
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (instr_done !== 1'b1 && n < 60);
		check("instr_done", 16'(instr_done), 16'h0001);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_escaped();
		put_code(8'h00, '{8'h04, 8'hE8, 8'h43});
		i_cpu_mem_model.regs[12'h128] = 8'h07;
		i_cpu_mem_model.regs[12'h143] = 8'h02;
		do_reset(8'h21);
		wait_done();
		check("paged dst", rf(12'h143), 16'h0009);
		check("working src", rf(12'h128), 16'h0007);
	endtask

	task automatic t_add_order();
		put_code(8'h00, '{8'h04, 8'h08, 8'h43, 8'h36, 8'h43, 8'h09, 8'hE0, 8'h50,
			8'hC0, 8'h51, 8'hC8, 8'h12, 8'h30, 8'hD8, 8'h06, 8'h00, 8'hAF});
		put_code(8'h20, '{8'h38, 8'h07, 8'h01, 8'h71, 8'h39, 8'h01, 8'h02, 8'h00});
		put_code(8'h29, '{8'hE1, 8'h52, 8'h33, 8'h23, 8'h39, 8'h04, 8'hEE, 8'hE6});
		foreach (i_cpu_mem_model.regs[i]) i_cpu_mem_model.regs[i] = 8'h00;
		i_cpu_mem_model.regs[12'h008] = 8'h05;
		i_cpu_mem_model.regs[12'h043] = 8'h03;
		i_cpu_mem_model.regs[12'h050] = 8'h01;
		i_cpu_mem_model.regs[12'h051] = 8'h02;
		i_cpu_mem_model.regs[12'h123] = 8'h5A;
		i_cpu_mem_model.regs[12'h001] = 8'h20;
		i_cpu_mem_model.regs[12'h070] = 8'h10;
		i_cpu_mem_model.regs[12'h171] = 8'h30;
		i_cpu_mem_model.regs[12'h052] = 8'h53;
		i_cpu_mem_model.regs[12'h053] = 8'h03;
		i_cpu_mem_model.regs[12'h003] = 8'h54;
		i_cpu_mem_model.regs[12'h054] = 8'h01;
		i_cpu_mem_model.regs[12'h002] = 8'h05;
		i_cpu_mem_model.regs[12'h006] = 8'h10;
		do_reset(8'h00);
		wait_done();
		check("add dst", rf(12'h043), 16'h0008);
		check("add src", rf(12'h008), 16'h0005);
	endtask

	task automatic t_sbc();
		wait_done();
		check("sbc dst", rf(12'h043), 16'h00FF);
		check("sbc flags", 16'(flags), 16'h0035);
	endtask

	task automatic t_rotates();
		wait_done();
		check("rr dst", rf(12'h050), 16'h0080);
		check("rr flags", 16'(flags), 16'h003D);
		wait_done();
		check("rrc dst", rf(12'h051), 16'h0081);
		check("rrc flags", 16'(flags), 16'h003C);
	endtask

	task automatic t_stack();
		wait_done();
		check("push sp", 16'(stack_pointer), 16'h0FFF);
		check("push mem", rf(12'hFFF), 16'h005A);
		check("push flags", 16'(flags), 16'h003C);
		wait_done();
		check("pop sp", 16'(stack_pointer), 16'h0000);
		check("pop dst", rf(12'h060), 16'h005A);
		wait_done();
		check("ret pc", pm_addr, 16'h0020);
		check("ret sp", 16'(stack_pointer), 16'h0002);
		check("ret flags", 16'(flags), 16'h003C);
	endtask

	task automatic t_subtract_with_borrow_extended();
		wait_done();
		check("subtract_with_borrow_extended dst", rf(12'h171), 16'h0020);
		check("subtract_with_borrow_extended flags", 16'(flags), 16'h0010);
		wait_done();
		check("subtract_with_borrow_extended imm", rf(12'h200), 16'h00FF);
		check("subtract_with_borrow_extended imm flags", 16'(flags), 16'h0035);
	endtask

	task automatic t_illegal();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (illegal_opcode !== 1'b1 && n < 20);
		check("illegal", 16'(illegal_opcode), 16'h0001);
		check("illegal sp", 16'(stack_pointer), 16'h0002);
		check("illegal flags", 16'(flags), 16'h0035);
	endtask

	task automatic t_indirect();
		wait_done();
		check("rr ind dst", rf(12'h053), 16'h0081);
		check("rr ind flags", 16'(flags), 16'h003D);
		wait_done();
		check("sbc work dst", rf(12'h002), 16'h0003);
		check("sbc work flags", 16'(flags), 16'h0010);
		wait_done();
		check("subtract_with_borrow_extended esc dst", rf(12'h006), 16'h000C);
		check("subtract_with_borrow_extended esc flags", 16'(flags), 16'h0030);
	endtask

	initial begin
		@(posedge clk);
		t_escaped();
		t_add_order();
		t_sbc();
		t_rotates();
		t_stack();
		t_subtract_with_borrow_extended();
		t_illegal();
		t_indirect();
		conclude();
	end
endmodule
